// File: rtl/hbpm_top.sv
module hbpm_top #(
  parameter int NUM_BRIDGES = 8,
  parameter bit STRAPPED    = 1'b0
) (
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  input  wire logic                        ce,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [hbpm_pkg::ADDR_W-1:0] paddr,
  input  wire logic [hbpm_pkg::DATA_W-1:0] pwdata,
  output logic      [hbpm_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        pwm_input_one,
  input  wire logic                        pwm_input_two,
  input  wire logic                        pwm_input_three,
  input  wire logic                        pwm_input_four,
  input  wire logic                        mode_strap,
  input  wire logic                        sleep_request_n,
  output logic      [NUM_BRIDGES-1:0]      high_gate_out,
  output logic      [NUM_BRIDGES-1:0]      low_gate_out
);
  localparam int N  = NUM_BRIDGES;
  localparam int N2 = 2 * NUM_BRIDGES;

  // Synchronised pins
  logic [hbpm_pkg::INPUTS+1:0] pinRaw;
  logic [hbpm_pkg::INPUTS+1:0] pinLvl;
  logic [hbpm_pkg::INPUTS-1:0] pwmLvl;
  logic                        strapLvl;
  logic                        awakeLvl;

  // Software fields
  logic [N2-1:0] half_bridge_state_sel;
  logic [N2-1:0] half_bridge_source_sel;
  logic [N-1:0]  bridge_drive_side_bit;
  logic [N-1:0]  bridge_freewheel_bit;
  logic [1:0]    bridge_scheme_sel;
  logic [N2-1:0] next_state_sel;
  logic [N2-1:0] next_source_sel;
  logic [N-1:0]  next_side;
  logic [N-1:0]  next_fwheel;
  logic [1:0]    next_scheme;

  // Bus answer
  logic [hbpm_pkg::DATA_W-1:0] next_prdata;
  logic                        next_pready;
  logic                        next_pslverr;
  logic                        wrStrobe;
  logic                        hitReg;

  // Strap capture
  hbpm_pkg::hbpm_cap_t capState;
  hbpm_pkg::hbpm_cap_t next_capState;
  logic                strapHeld;
  logic                next_strapHeld;

  // Gate demand
  logic [N-1:0] wantHigh;
  logic [N-1:0] wantLow;
  logic         schemeOn;

  // Two-bit field of bridge i within a packed vector
  function automatic logic [1:0] fieldOf(input logic [N2-1:0] vec, input int i);
    fieldOf = vec[2*i +: 2];
  endfunction : fieldOf

  // Write data cut to the N2-bit width of a field register
  function automatic logic [N2-1:0] wide(input logic [hbpm_pkg::DATA_W-1:0] d);
    wide = d[N2-1:0];
  endfunction : wide

  // True for every mapped register offset
  function automatic logic isReg(input logic [hbpm_pkg::ADDR_W-1:0] a);
    unique case (a)
      hbpm_pkg::OFS_STATE,
      hbpm_pkg::OFS_ROUTE,
      hbpm_pkg::OFS_SIDE,
      hbpm_pkg::OFS_FWHEEL,
      hbpm_pkg::OFS_SCHEME,
      hbpm_pkg::OFS_GATES,
      hbpm_pkg::OFS_STRAP: isReg = 1'b1;
      default:             isReg = 1'b0;
    endcase
  endfunction : isReg

  // Pins gathered for the synchroniser, sleep and strap on top
  assign pinRaw = {sleep_request_n, mode_strap, pwm_input_four,
                   pwm_input_three, pwm_input_two, pwm_input_one};

  // Every pin crosses a three-flop chain and then the filtered level flop
  hbpm_pin_sync #(
    .W (hbpm_pkg::INPUTS + 2)
  ) u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .ce     (ce),
    .pin    (pinRaw),
    .level  (pinLvl)
  );

  assign pwmLvl   = pinLvl[hbpm_pkg::INPUTS-1:0];
  assign strapLvl = pinLvl[hbpm_pkg::INPUTS];
  assign awakeLvl = pinLvl[hbpm_pkg::INPUTS+1];

  // Strap is caught once after reset and again after each wake-up
  always_comb begin
    next_capState  = capState;
    next_strapHeld = strapHeld;
    unique case (capState)
      hbpm_pkg::CAP_GRAB: begin
        if (awakeLvl) begin
          next_strapHeld = strapLvl;
          next_capState  = hbpm_pkg::CAP_RUN;
        end
      end
      hbpm_pkg::CAP_RUN: begin
        if (!awakeLvl) begin
          next_capState = hbpm_pkg::CAP_SLEEP;
        end
      end
      hbpm_pkg::CAP_SLEEP: begin
        if (awakeLvl) begin
          next_capState = hbpm_pkg::CAP_GRAB;
        end
      end
      default: begin
        next_capState = hbpm_pkg::CAP_GRAB;
      end
    endcase
  end

  // Capture state and held strap
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      capState  <= hbpm_pkg::CAP_GRAB;
      strapHeld <= 1'b0;
    end else if (ce) begin
      capState  <= next_capState;
      strapHeld <= next_strapHeld;
    end
  end

  // Access phase lasts two cycles; a write lands with pready
  assign wrStrobe = psel & penable & pready & pwrite;
  assign hitReg   = isReg(paddr);

  // Field registers; effect on gates follows one cycle later
  always_comb begin
    next_state_sel  = half_bridge_state_sel;
    next_source_sel = half_bridge_source_sel;
    next_side       = bridge_drive_side_bit;
    next_fwheel     = bridge_freewheel_bit;
    next_scheme     = bridge_scheme_sel;
    if (wrStrobe) begin
      unique case (paddr)
        hbpm_pkg::OFS_STATE:  next_state_sel  = wide(pwdata);
        hbpm_pkg::OFS_ROUTE:  next_source_sel = wide(pwdata);
        hbpm_pkg::OFS_SIDE:   next_side       = pwdata[N-1:0];
        hbpm_pkg::OFS_FWHEEL: next_fwheel     = pwdata[N-1:0];
        hbpm_pkg::OFS_SCHEME: next_scheme     = pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Field register flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      half_bridge_state_sel  <= N2'(hbpm_pkg::RST_STATE);
      half_bridge_source_sel <= N2'(hbpm_pkg::RST_ROUTE);
      bridge_drive_side_bit  <= N'(hbpm_pkg::RST_SIDE);
      bridge_freewheel_bit   <= N'(hbpm_pkg::RST_FWHEEL);
      bridge_scheme_sel      <= hbpm_pkg::RST_SCHEME;
    end else if (ce) begin
      half_bridge_state_sel  <= next_state_sel;
      half_bridge_source_sel <= next_source_sel;
      bridge_drive_side_bit  <= next_side;
      bridge_freewheel_bit   <= next_fwheel;
      bridge_scheme_sel      <= next_scheme;
    end
  end

  // Read mux, unmapped addresses give an error
  always_comb begin
    next_pready  = psel & penable & ~pready;
    next_pslverr = 1'b0;
    next_prdata  = '0;
    if (next_pready) begin
      next_pslverr = ~hitReg;
      if (!pwrite) begin
        unique case (paddr)
          hbpm_pkg::OFS_STATE:  next_prdata[N2-1:0] = half_bridge_state_sel;
          hbpm_pkg::OFS_ROUTE:  next_prdata[N2-1:0] = half_bridge_source_sel;
          hbpm_pkg::OFS_SIDE:   next_prdata[N-1:0]  = bridge_drive_side_bit;
          hbpm_pkg::OFS_FWHEEL: next_prdata[N-1:0]  = bridge_freewheel_bit;
          hbpm_pkg::OFS_SCHEME: next_prdata[1:0]    = bridge_scheme_sel;
          hbpm_pkg::OFS_GATES:  next_prdata[N2-1:0] = {low_gate_out, high_gate_out};
          hbpm_pkg::OFS_STRAP:  next_prdata[1:0]    = {awakeLvl, strapHeld};
          default: ;
        endcase
      end
    end
  end

  // Bus answer flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Half-bridge scheme enable; eight-bridge parts have only this scheme
  always_comb begin
    if (N > hbpm_pkg::INPUTS) begin
      schemeOn = 1'b1;
    end else if (STRAPPED) begin
      schemeOn = strapHeld;
    end else begin
      schemeOn = (bridge_scheme_sel == hbpm_pkg::SCHEME_HALF);
    end
    schemeOn = schemeOn & (capState == hbpm_pkg::CAP_RUN);
  end

  // Per-bridge demand and dead-time stage
  for (genvar g = 0; g < N; g++) begin : g_bridge
    logic [1:0] stateSel;
    logic [1:0] srcSel;
    logic       side;
    logic       fwheel;
    logic       pwm;

    // Field decode into gate demand
    always_comb begin
      if (STRAPPED) begin
        stateSel = hbpm_pkg::ST_PWM;
        srcSel   = 2'(g % hbpm_pkg::INPUTS);
        side     = hbpm_pkg::SIDE_HIGH;
        fwheel   = hbpm_pkg::FW_ACTIVE;
      end else begin
        stateSel = fieldOf(half_bridge_state_sel, g);
        srcSel   = fieldOf(half_bridge_source_sel, g);
        side     = bridge_drive_side_bit[g];
        fwheel   = bridge_freewheel_bit[g];
      end
      pwm = pwmLvl[srcSel];
      wantHigh[g] = 1'b0;
      wantLow[g]  = 1'b0;
      unique case (stateSel)
        hbpm_pkg::ST_OFF:  ;
        hbpm_pkg::ST_LOW:  wantLow[g]  = 1'b1;
        hbpm_pkg::ST_HIGH: wantHigh[g] = 1'b1;
        hbpm_pkg::ST_PWM: begin
          if (side == hbpm_pkg::SIDE_HIGH) begin
            wantHigh[g] = pwm;
            wantLow[g]  = ~pwm & (fwheel == hbpm_pkg::FW_ACTIVE);
          end else begin
            wantLow[g]  = pwm;
            wantHigh[g] = ~pwm & (fwheel == hbpm_pkg::FW_ACTIVE);
          end
        end
      endcase
    end

    // Dead-time stage drives the gate pins
    hbpm_dead_time u_dead (
      .clock    (clock),
      .arst_n   (arst_n),
      .ce       (ce),
      .wantHigh (wantHigh[g] & schemeOn),
      .wantLow  (wantLow[g] & schemeOn),
      .highGate (high_gate_out[g]),
      .lowGate  (low_gate_out[g])
    );
  end
endmodule : hbpm_top

// File: rtl/hbpm_pkg.sv
package hbpm_pkg;
  localparam int        ADDR_W       = 8;
  localparam int        DATA_W       = 32;
  localparam int        INPUTS       = 4;
  // Register byte offsets
  localparam bit [7:0]  OFS_STATE    = 8'h00;
  localparam bit [7:0]  OFS_ROUTE    = 8'h04;
  localparam bit [7:0]  OFS_SIDE     = 8'h08;
  localparam bit [7:0]  OFS_FWHEEL   = 8'h0C;
  localparam bit [7:0]  OFS_SCHEME   = 8'h10;
  localparam bit [7:0]  OFS_GATES    = 8'h14;
  localparam bit [7:0]  OFS_STRAP    = 8'h18;
  // Bridge state, scheme, side and freewheel codes
  localparam bit [1:0]  ST_OFF       = 2'h0;
  localparam bit [1:0]  ST_LOW       = 2'h1;
  localparam bit [1:0]  ST_HIGH      = 2'h2;
  localparam bit [1:0]  ST_PWM       = 2'h3;
  localparam bit [1:0]  SCHEME_HALF  = 2'h0;
  localparam bit        SIDE_HIGH    = 1'h0;
  localparam bit        FW_ACTIVE    = 1'h0;
  // Reset values
  localparam bit [15:0] RST_STATE    = 16'h0000;
  localparam bit [15:0] RST_ROUTE    = 16'h0000;
  localparam bit [7:0]  RST_SIDE     = 8'h00;
  localparam bit [7:0]  RST_FWHEEL   = 8'h00;
  localparam bit [1:0]  RST_SCHEME   = 2'h0;
  // Dead time and clock rate
  localparam int        CLOCK_MHZ    = 200;
  localparam int        DEAD_NS      = 100;
  localparam int        DEAD_CYC     = (DEAD_NS * CLOCK_MHZ + 999) / 1000;
  localparam int        DEAD_W       = 8;
  // Strap capture sequencer
  typedef enum logic [2:0] {
    CAP_GRAB  = 3'b001,
    CAP_RUN   = 3'b010,
    CAP_SLEEP = 3'b100
  } hbpm_cap_t;
endpackage : hbpm_pkg

// File: rtl/hbpm_pin_sync.sv
module hbpm_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_level;

  // A bit changes once the second and third stages agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_level[i] = (s2[i] == s3[i]) ? s3[i] : level[i];
    end
  end

  // Three-stage chain and filtered level
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      level <= '0;
    end else if (ce) begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end
endmodule : hbpm_pin_sync

// File: rtl/hbpm_dead_time.sv
module hbpm_dead_time #(
  parameter logic [hbpm_pkg::DEAD_W-1:0] DEAD = hbpm_pkg::DEAD_CYC[hbpm_pkg::DEAD_W-1:0]
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic ce,
  input  wire logic wantHigh,
  input  wire logic wantLow,
  output logic      highGate,
  output logic      lowGate
);
  logic [hbpm_pkg::DEAD_W-1:0] gapCount;
  logic [hbpm_pkg::DEAD_W-1:0] next_wait;
  logic                        next_high;
  logic                        next_low;

  // A gate turns on only after the other is off and the gap has run out
  always_comb begin
    next_high = highGate & wantHigh;
    next_low  = lowGate & wantLow;
    next_wait = gapCount;
    if ((highGate & ~wantHigh) | (lowGate & ~wantLow)) begin
      next_wait = DEAD;
    end else if (gapCount != '0) begin
      next_wait = gapCount - 1'b1;
    end
    if (wantHigh & ~lowGate & (gapCount == '0)) begin
      next_high = 1'b1;
    end
    if (wantLow & ~highGate & (gapCount == '0)) begin
      next_low = 1'b1;
    end
  end

  // Gate flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      highGate <= 1'b0;
      lowGate  <= 1'b0;
      gapCount <= '0;
    end else if (ce) begin
      highGate <= next_high;
      lowGate  <= next_low;
      gapCount <= next_wait;
    end
  end
endmodule : hbpm_dead_time

// File: bench/hbpm_checker_assertions.sv
module hbpm_checker #(
  parameter int NUM_BRIDGES = 8,
  parameter bit STRAPPED    = 1'b0
) (
  input wire logic                        clock,
  input wire logic                        arst_n,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [hbpm_pkg::ADDR_W-1:0] paddr,
  input wire logic [hbpm_pkg::DATA_W-1:0] pwdata,
  input wire logic [hbpm_pkg::DATA_W-1:0] prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        sleep_request_n,
  input wire logic [NUM_BRIDGES-1:0]      high_gate_out,
  input wire logic [NUM_BRIDGES-1:0]      low_gate_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Bus answer shape
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  ready_access_a: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside access phase");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  err_read_a: assert property (pslverr && !pwrite |-> prdata == '0) else $error("refused read not zero");
  // Gate safety
  gate_overlap_a: assert property ((high_gate_out & low_gate_out) == '0)
    else $error("both gates on");
  dead_gap_a: assert property ($fell(high_gate_out[0]) |-> !low_gate_out[0] [*8])
    else $error("dead time too short");
  dead_gap_low_a: assert property ($fell(low_gate_out[0]) |-> !high_gate_out[0] [*8])
    else $error("dead time too short");
  sleep_off_a: assert property (!sleep_request_n [*8] |-> high_gate_out == '0 && low_gate_out == '0)
    else $error("gates on in sleep");
  // Off code reaches the gates within one to three cycles
  off_write_a: assert property (pready && pwrite && !pslverr && paddr == hbpm_pkg::OFS_STATE &&
    pwdata[1:0] == hbpm_pkg::ST_OFF && !STRAPPED |-> ##[1:3] !high_gate_out[0] && !low_gate_out[0])
    else $error("off code not applied");
endmodule : hbpm_checker

bind hbpm_top hbpm_checker #(.NUM_BRIDGES(NUM_BRIDGES), .STRAPPED(STRAPPED)) u_hbpm_checker (
  .clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .sleep_request_n, .high_gate_out, .low_gate_out);

// File: bench/hbpm_pwm_ctrl.sv
module hbpm_pwm_ctrl (
  input  wire logic       clock,
  input  wire logic [3:0] duty,
  output logic      [3:0] pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // Timer outputs of the controller change just after the edge
  always_ff @(posedge clock) begin
    pins <= duty;
  end
endmodule : hbpm_pwm_ctrl

// File: bench/hbpm_top_tb.sv
module hbpm_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep_request_n;
  logic [3:0]  lev;
  logic [3:0]  pins;
  logic [7:0]  highGate;
  logic [7:0]  lowGate;
  logic [3:0]  highGate4;
  logic [3:0]  lowGate4;
  logic        ce;
  logic        strap;
  logic [31:0] q;
  logic        e;
  logic [15:0] rt;
  logic [7:0]  sd;
  logic [7:0]  fw;
  int          nErrors;
  int          checksDone;

  hbpm_pwm_ctrl u_hbpm_pwm_ctrl (.clock(clock), .duty(lev), .pins(pins));
  hbpm_top #(.NUM_BRIDGES(8), .STRAPPED(1'b0)) u_hbpm_top (
    .clock(clock), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_input_one(pins[0]), .pwm_input_two(pins[1]), .pwm_input_three(pins[2]),
    .pwm_input_four(pins[3]), .mode_strap(1'b0), .sleep_request_n(sleep_request_n),
    .high_gate_out(highGate), .low_gate_out(lowGate));
  // Strapped four-bridge build on the same pins, bus idle
  hbpm_top #(.NUM_BRIDGES(4), .STRAPPED(1'b1)) u_hbpm_top_strap (
    .clock(clock), .arst_n(arst_n), .ce(ce), .psel(1'b0), .penable(1'b0), .pwrite(1'b0),
    .paddr(8'h00), .pwdata(32'h0), .prdata(), .pready(), .pslverr(),
    .pwm_input_one(pins[0]), .pwm_input_two(pins[1]), .pwm_input_three(pins[2]),
    .pwm_input_four(pins[3]), .mode_strap(strap), .sleep_request_n(sleep_request_n),
    .high_gate_out(highGate4), .low_gate_out(lowGate4));

  task automatic stopTest();
    if (nErrors == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stopTest

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One bus transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge clock);
    if (n == 50) begin
      nErrors++;
      stopTest();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  // Gate pattern {low, high} from the field values
  function automatic logic [15:0] expGates(input logic [1:0] st, input logic [3:0] lv);
    logic [15:0] g;
    logic        p;
    g = '0;
    for (int i = 0; i < 8; i++) begin
      p = lv[rt[2*i+:2]];
      case (st)
        hbpm_pkg::ST_LOW:  g[8+i] = 1'b1;
        hbpm_pkg::ST_HIGH: g[i] = 1'b1;
        hbpm_pkg::ST_PWM: begin
          g[i]   = sd[i] ? !p && !fw[i] : p;
          g[8+i] = sd[i] ? p : !p && !fw[i];
        end
        default: g = g;
      endcase
    end
    return g;
  endfunction : expGates

  // Wait out dead time and pin sync, then compare pins and readback
  task automatic gateCheck(input logic [1:0] st);
    repeat (40) @(posedge clock);
    check({16'h0, lowGate, highGate}, {16'h0, expGates(st, lev)});
    apb(1'b0, hbpm_pkg::OFS_GATES, 32'h0);
    check(q, {16'h0, expGates(st, lev)});
    check({24'h0, lowGate4, highGate4}, {24'h0, ~lev, lev});
  endtask : gateCheck

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sleep_request_n = 1'b1;
    ce = 1'b1;
    strap = 1'b1;
    lev = 4'h0;
    rt = 16'h0;
    sd = 8'h00;
    fw = 8'h00;
    nErrors = 0;
    checksDone = 0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (8) @(posedge clock);
    apb(1'b0, hbpm_pkg::OFS_STATE, 32'h0);
    check(q, {16'h0, hbpm_pkg::RST_STATE});
    apb(1'b0, hbpm_pkg::OFS_ROUTE, 32'h0);
    check(q, {16'h0, hbpm_pkg::RST_ROUTE});
    apb(1'b1, 8'h40, 32'hFFFF);
    check({q[30:0], e}, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    check({q[30:0], e}, 32'h1);
    apb(1'b0, hbpm_pkg::OFS_STRAP, 32'h0);
    check(q, 32'h2);
    // Fixed states on all bridges
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, hbpm_pkg::OFS_STATE, {16'h0, {8{2'(c)}}});
      gateCheck(2'(c));
    end
    // PWM routing, side and freewheel combinations
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 4; k++) begin
        rt = r ? 16'hFFFF : 16'hE4E4;
        sd = {8{k[0]}};
        fw = {8{k[1]}};
        apb(1'b1, hbpm_pkg::OFS_STATE, 32'h0);
        apb(1'b1, hbpm_pkg::OFS_ROUTE, {16'h0, rt});
        apb(1'b0, hbpm_pkg::OFS_ROUTE, 32'h0);
        check(q, {16'h0, rt});
        apb(1'b1, hbpm_pkg::OFS_SIDE, {24'h0, sd});
        apb(1'b1, hbpm_pkg::OFS_FWHEEL, {24'h0, fw});
        apb(1'b1, hbpm_pkg::OFS_STATE, 32'hFFFF);
        foreach (sd[v]) begin
          if (v < 3) begin
            lev <= 4'(4'h5 << v);
            @(posedge clock);
            gateCheck(hbpm_pkg::ST_PWM);
          end
        end
      end
    end
    // Clock enable low freezes the gates while the pins move
    ce  <= 1'b0;
    lev <= ~lev;
    repeat (40) @(posedge clock);
    check({16'h0, lowGate, highGate}, {16'h0, expGates(hbpm_pkg::ST_PWM, ~lev)});
    check({24'h0, lowGate4, highGate4}, {24'h0, lev, ~lev});
    ce  <= 1'b1;
    gateCheck(hbpm_pkg::ST_PWM);
    // Strap moves while awake: no effect until a wake-up
    strap <= 1'b0;
    repeat (40) @(posedge clock);
    check({24'h0, lowGate4, highGate4}, {24'h0, ~lev, lev});
    // Sleep forces every gate low
    apb(1'b1, hbpm_pkg::OFS_STATE, 32'hAAAA);
    sleep_request_n <= 1'b0;
    repeat (12) @(posedge clock);
    check({16'h0, lowGate, highGate}, 32'h0);
    check({24'h0, lowGate4, highGate4}, 32'h0);
    // Wake-up recaptures the strap, which now turns the strapped scheme off
    sleep_request_n <= 1'b1;
    repeat (40) @(posedge clock);
    check({24'h0, lowGate4, highGate4}, 32'h0);
    check({16'h0, lowGate, highGate}, 32'h0000_00FF);
    stopTest();
  end
endmodule : hbpm_top_tb
